/* File: ldd_regs.sv */
// led3..led6 dimming registers with avalon-mm slave and pwm compare
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ldd_map.svh"
// Operation
// - each led register reads back the last written duty and fade bit.
// - duty code is linear; zero is off, all ones is on for whole period.
// - bit 12 steers its own led only; zero enables fading, one disables.
// - four consecutive register indices select led3 through led6, one each.
// - a group duty write copies the group duty into every member led, except duty bytes that a bus write to that led enables in the same cycle.
module ldd_regs #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // group duty copy from the group register logic
    input wire logic grp_wr,
    input wire ldd_pkg::ldd_duty_t grp_duty,
    input wire logic [3:0] grp_member,
    // per-led outputs
    output logic [3:0] led_on,
    output logic [3:0] fade_en
);
    import ldd_pkg::*;

    // -------------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------------
    function automatic logic [4:0] ldd_decode(input logic [ADDR_W-1:0] a);
        logic [4:0] r;
        r = 5'h00;
        if (a[1:0] == 2'b00) begin
            case (a[ADDR_W-1:2])
                (ADDR_W-2)'(`LDD_IDX_LED3_DIMMING): r = 5'h10;
                (ADDR_W-2)'(`LDD_IDX_LED4_DIMMING): r = 5'h11;
                (ADDR_W-2)'(`LDD_IDX_LED5_DIMMING): r = 5'h12;
                (ADDR_W-2)'(`LDD_IDX_LED6_DIMMING): r = 5'h13;
                default: r = 5'h00;
            endcase
        end
        return r;
    endfunction : ldd_decode

    function automatic logic ldd_pwm_hit(input ldd_duty_t duty, input ldd_duty_t cnt);
        return cnt < duty;
    endfunction : ldd_pwm_hit

    ldd_state_t state_q, state_d;
    ldd_reg_t regs_q [4];
    ldd_reg_t regs_d [4];
    logic [31:0] rdata_q, rdata_d;
    ldd_duty_t cnt_q, cnt_d;
    logic [3:0] led_on_q, led_on_d;
    logic [4:0] hit;
    logic req;

    assign req = avs_read | avs_write;
    assign hit = ldd_decode(avs_address);
    assign avs_waitrequest = req & (state_q != LDD_ST_DONE);
    assign avs_readdata = rdata_q;
    assign led_on = led_on_q;

    // -------------------------------------------------------------------------
    // bus slave and register file
    // -------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        for (int i = 0; i < 4; i++) begin
            regs_d[i] = regs_q[i];
            if (grp_wr && grp_member[i]) begin
                regs_d[i][`LDD_DUTY_MSB:`LDD_DUTY_LSB] = grp_duty;
            end
        end
        case (state_q)
            LDD_ST_IDLE: begin
                if (req) begin
                    state_d = LDD_ST_DONE;
                    rdata_d = 32'h0000_0000;
                    if (hit[4] && avs_read) begin
                        rdata_d = {19'h0_0000, regs_q[hit[1:0]]};
                    end
                    if (hit[4] && avs_write) begin
                        if (avs_byteenable[0]) begin
                            regs_d[hit[1:0]][7:0] = avs_writedata[7:0];
                        end
                        if (avs_byteenable[1]) begin
                            regs_d[hit[1:0]][12:8] = avs_writedata[12:8];
                        end
                    end
                end
            end
            LDD_ST_DONE: begin
                state_d = LDD_ST_IDLE;
            end
            default: begin
                state_d = LDD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= LDD_ST_IDLE;
            rdata_q <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                regs_q[i] <= `LDD_REG_RESET;
            end
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < 4; i++) begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    // -------------------------------------------------------------------------
    // pwm compare
    // -------------------------------------------------------------------------
    always_comb begin
        cnt_d = (cnt_q == `LDD_PWM_LAST) ? 12'h000 : cnt_q + 12'h001;
        for (int i = 0; i < 4; i++) begin
            led_on_d[i] = ldd_pwm_hit(regs_q[i][`LDD_DUTY_MSB:`LDD_DUTY_LSB], cnt_q);
            fade_en[i] = ~regs_q[i][`LDD_FADE_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 12'h000;
            led_on_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
            led_on_q <= led_on_d;
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    a_bus_wait_one: assert property (@(posedge clk) disable iff (!reset_n)
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");

    a_unmapped_no_write: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == LDD_ST_IDLE && avs_write && !hit[4] && !grp_wr |=>
        {regs_q[0], regs_q[1], regs_q[2], regs_q[3]}
        == $past({regs_q[0], regs_q[1], regs_q[2], regs_q[3]}))
        else $error("unmapped write changed a register");

    a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == LDD_ST_IDLE && avs_read && !hit[4] |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    a_readdata_stands: assert property (@(posedge clk) disable iff (!reset_n)
        !(state_q == LDD_ST_IDLE && req) |=> $stable(avs_readdata))
        else $error("read data changed without a request");

    a_pwm_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        cnt_q == `LDD_PWM_LAST |=> cnt_q == 12'h000)
        else $error("pwm counter did not wrap at period end");

    a_pwm_count_range: assert property (@(posedge clk) disable iff (!reset_n)
        cnt_q <= `LDD_PWM_LAST)
        else $error("pwm counter left its period");

    a_reset_clears_regs: assert property (@(posedge clk)
        $rose(reset_n) |-> (regs_q[0] == 13'h0000) && (regs_q[1] == 13'h0000)
        && (regs_q[2] == 13'h0000) && (regs_q[3] == 13'h0000))
        else $error("registers not cleared by reset");

    // -------------------------------------------------------------------------
    // per-led checks
    // -------------------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_chk
        a_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
            state_q == LDD_ST_IDLE && avs_write && hit[4] && hit[1:0] == 2'(g)
            && avs_byteenable[1:0] == 2'b11
            |=> regs_q[g] == $past(avs_writedata[12:0]))
            else $error("write did not land in its register");

        a_write_reads_back: assert property (@(posedge clk) disable iff (!reset_n)
            state_q == LDD_ST_IDLE && avs_read && hit[4] && hit[1:0] == 2'(g)
            |=> avs_readdata == {19'h0_0000, $past(regs_q[g])})
            else $error("read did not return the register value");

        a_duty_zero_off: assert property (@(posedge clk) disable iff (!reset_n)
            $past(regs_q[g][11:0]) == 12'h000 && $past(reset_n) |-> !led_on[g])
            else $error("led on with zero duty");

        a_duty_full_on: assert property (@(posedge clk) disable iff (!reset_n)
            $past(regs_q[g][11:0]) == 12'hFFF && $past(reset_n) |-> led_on[g])
            else $error("led off with full duty");

        a_fade_polarity: assert property (@(posedge clk) disable iff (!reset_n)
            state_q == LDD_ST_IDLE && avs_write && hit[4] && hit[1:0] == 2'(g)
            && avs_byteenable[1] |=> fade_en[g] == !$past(avs_writedata[12]))
            else $error("fade enable polarity wrong");

        a_group_copy: assert property (@(posedge clk) disable iff (!reset_n)
            grp_wr && grp_member[g] && !(state_q == LDD_ST_IDLE && avs_write && hit[4])
            |=> regs_q[g][11:0] == $past(grp_duty))
            else $error("group duty not copied");

        a_group_keeps_fade: assert property (@(posedge clk) disable iff (!reset_n)
            grp_wr && grp_member[g] && !(state_q == LDD_ST_IDLE && avs_write && hit[4])
            |=> regs_q[g][12] == $past(regs_q[g][12]))
            else $error("group copy changed the fade bit");
    end
endmodule : ldd_regs
`default_nettype wire

/* File: ldd_map.svh */
// register map and timing constants for the led3..led6 dimming registers
`ifndef LDD_MAP_SVH
`define LDD_MAP_SVH
// -------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -------------------------------------------------------------------------
`define LDD_IDX_LED3_DIMMING 8'h44
`define LDD_IDX_LED4_DIMMING 8'h45
`define LDD_IDX_LED5_DIMMING 8'h46
`define LDD_IDX_LED6_DIMMING 8'h47
// -------------------------------------------------------------------------
// field layout and reset values
// -------------------------------------------------------------------------
`define LDD_DUTY_MSB 11
`define LDD_DUTY_LSB 0
`define LDD_FADE_BIT 12
`define LDD_REG_W 13
`define LDD_REG_RESET 13'h0000
`define LDD_DUTY_OFF 12'h000
`define LDD_DUTY_FULL 12'hFFF
// -------------------------------------------------------------------------
// last pwm count, one less than the 4095-cycle period (codes 0..4095 map to 0..4095 of it)
// -------------------------------------------------------------------------
`define LDD_PWM_LAST 12'hFFE
`endif

/* File: ldd_pkg.sv */
// types for the led dimming register bank
`default_nettype none
package ldd_pkg;
    typedef logic [12:0] ldd_reg_t;
    typedef logic [11:0] ldd_duty_t;
    typedef enum logic [1:0] {
        LDD_ST_IDLE = 2'b00,
        LDD_ST_DONE = 2'b01
    } ldd_state_t;
endpackage : ldd_pkg
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the led dimming register bank
`timescale 1ns/1ps
`default_nettype none
`include "ldd_map.svh"
module tb_top;
    import ldd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic grp_wr = 1'b0;
    ldd_duty_t grp_duty = 12'h000;
    logic [3:0] grp_member = 4'h0;
    logic [3:0] led_on;
    logic [3:0] fade_en;
    int miscompares = 0;
    int check_count = 0;
    int on_cnt [4] = '{0, 0, 0, 0};
    always #12.5 clk = ~clk;
    ldd_regs #(.ADDR_W(10)) u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .grp_wr(grp_wr), .grp_duty(grp_duty),
        .grp_member(grp_member), .led_on(led_on), .fade_en(fade_en));
    // ------------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_cnt
    function automatic logic [9:0] adr(input int i);
        return 10'((`LDD_IDX_LED3_DIMMING + i) * 4);
    endfunction : adr
    // request held until waitrequest is sampled low, then released
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        xfer(1'b1, a, d, be, q);
    endtask : wr
    task automatic rd_check(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, 4'hF, q);
        check_word(q, exp);
    endtask : rd_check
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        #(25ns * 30000);
        miscompares++;
        finish_test();
    end
    initial begin
        logic [31:0] v [4];
        v = '{32'h00001ABC, 32'h00000DEF, 32'h00001001, 32'h00000FFF};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check_word({28'h0, fade_en}, 32'h0000000F);
        for (int i = 0; i < 4; i++) rd_check(adr(i), 32'h0);
        for (int i = 0; i < 4; i++) wr(adr(i), v[i] | 32'hFFFFE000, 4'hF);
        for (int i = 0; i < 4; i++) rd_check(adr(i), v[i]);
        check_word({28'h0, fade_en}, 32'h0000000A);
        wr(adr(4), 32'h00000FFF, 4'hF);
        rd_check(adr(4), 32'h0);
        rd_check(adr(0) + 10'h001, 32'h0);
        wr(adr(1), 32'h00001FFF, 4'h1);
        rd_check(adr(1), 32'h00000DFF);
        grp_duty <= 12'hAAA;
        grp_member <= 4'b0101;
        grp_wr <= 1'b1;
        @(posedge clk);
        grp_wr <= 1'b0;
        @(posedge clk);
        rd_check(adr(0), 32'h00001AAA);
        rd_check(adr(1), 32'h00000DFF);
        rd_check(adr(2), 32'h00001AAA);
        rd_check(adr(3), 32'h00000FFF);
        v = '{32'h00000000, 32'h00000FFF, 32'h00000001, 32'h00000800};
        for (int i = 0; i < 4; i++) wr(adr(i), v[i], 4'h3);
        repeat (4095) @(posedge clk);
        for (int c = 0; c < 4095; c++) begin
            @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                if (led_on[k] === 1'b1) begin
                    on_cnt[k] += 1;
                end else if (led_on[k] !== 1'b0) begin
                    on_cnt[k] += 9999;
                end
            end
        end
        check_cnt(on_cnt[0], 0);
        check_cnt(on_cnt[1], 4095);
        check_cnt(on_cnt[2], 1);
        check_cnt(on_cnt[3], 2048);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
